/* shared/pwf_map.svh */
`ifndef PWF_MAP_SVH
`define PWF_MAP_SVH

// Register offsets on the local register port
`define PWF_OFS_MODULE_ENABLE   8'hCF
`define PWF_OFS_CONTROL         8'hD2
`define PWF_OFS_PERIOD_LOW      8'hD3
`define PWF_OFS_PERIOD_HIGH     8'hD4
`define PWF_OFS_DUTY_LOW        8'hD5
`define PWF_OFS_DUTY_HIGH       8'hD6
`define PWF_OFS_WRITE_LOCK      8'hE7
`define PWF_OFS_SYS_IRQ_ENABLE  8'hE8

// Control register fields
`define PWF_CTL_IRQ_ENABLE      7
`define PWF_CTL_IRQ_FLAG        6
`define PWF_CTL_FAULT_STATUS    4
`define PWF_CTL_FAULT_LEVEL     3
`define PWF_CTL_POLARITY        2
`define PWF_CTL_PSC_HI          1
`define PWF_CTL_PSC_LO          0

// Module enable register fields
`define PWF_EN_FAULT_DETECT     6
`define PWF_EN_COMPLEMENT       3
`define PWF_EN_PRIMARY          0

// System interrupt enable register field
`define PWF_SYS_IRQ_BIT         0

// Reset values and the unlock key
`define PWF_RST_BYTE            8'h00
`define PWF_UNLOCK_KEY          8'h55

// Prescaler: oscillator clocks per modulator clock, less one
`define PWF_DIV2_M1             4'h1
`define PWF_DIV4_M1             4'h3
`define PWF_DIV8_M1             4'h7
`define PWF_DIV16_M1            4'hF

`endif

/* shared/pwf_pkg.sv */
package pwf_pkg;

  typedef enum logic [1:0] {
    PWF_PSC_DIV2,
    PWF_PSC_DIV4,
    PWF_PSC_DIV8,
    PWF_PSC_DIV16
  } pwf_psc_t;

  // Settings that are latched together at each period boundary
  typedef struct packed {
    logic        polarity;
    pwf_psc_t    prescale;
    logic [11:0] period;
    logic [11:0] duty;
  } pwf_cfg_t;

endpackage : pwf_pkg

/* rtl/pwf_modulator.sv */
`timescale 1ns/1ps
`include "pwf_map.svh"
// Overview of operation
// - Period is a 12-bit value, low byte plus high nibble, in modulator clocks.
// - Duty is a 12-bit value, low byte plus high nibble, in modulator clocks.
// - Clock select divides oscillator clock by 2, 4, 8 or 16 for codes 0..3.
// - Polarity zero: high during duty, low otherwise; polarity one inverts.
// - Period zero: primary output constantly at the polarity level.
// - Period not above duty: primary output constantly at the active level.
// - Polarity, clock select, period, duty writes take effect at the next period start.
// - Period counter overflow sets control bit 6 until software writes zero.
// - Interrupt request needs control bit 7 and the system enable bit.
// - Fault level select zero faults on low pin, one faults on high.
// - Fault sets fault status and holds both outputs inactive until cleared.
// - Clearing fault status fails while the fault level is still present.
// - Inactive state: both outputs low with polarity zero, high with one.
// - Complementary output is the primary waveform inverted, generated in hardware.
// - Complementary output runs on its own enable even without the primary.
// - Fault pin acts only when fault detect is enabled.
// - Enable, control, period and duty writes need the unlock key in the lock.
// - Enable bit 6 fault detect, bit 3 complementary pin, bit 0 primary pin.
// - Clearing the module enable register disables the outputs at once.
module pwf_modulator
  import pwf_pkg::*;
(
  input  wire logic       clk_sys,              // Oscillator clock
  input  wire logic       nrst,                 // Synchronous reset, active low
  input  wire logic [7:0] reg_addr,             // Register address
  input  wire logic [7:0] reg_wdata,            // Register write data
  input  wire logic       reg_wr,               // Write strobe
  input  wire logic       reg_rd,               // Read strobe
  output logic      [7:0] reg_rdata,            // Read data, cycle after strobe
  input  wire logic       fault_pin,            // Fault input pin, asynchronous
  output logic            primary_output,       // Primary modulator output
  output logic            complementary_output, // Complementary modulator output
  output logic            primary_pin_en,       // Primary output routed to its pin
  output logic            complement_pin_en,    // Complementary output routed to its pin
  output logic            irq_req               // Interrupt request to the processor
);

  // Software-visible state
  logic [7:0] write_lock;
  logic       fault_detect_enable;
  logic       complement_output_enable;
  logic       primary_output_enable;
  logic       period_irq_enable;
  logic       period_irq_flag;
  logic       fault_status;
  logic       fault_level_select;
  logic       output_polarity;
  pwf_psc_t   prescaler_select;
  logic [7:0] period_low_byte;
  logic [3:0] period_high_nibble;
  logic [7:0] duty_low_byte;
  logic [3:0] duty_high_nibble;
  logic       system_modulator_irq_enable;

  // Working state
  pwf_cfg_t   act;
  logic [3:0] psc_cnt;
  logic       tick;
  logic [11:0] cnt;
  logic       wrap;
  logic       running;
  logic       raw_level;
  logic       next_primary;
  logic       next_complement;
  logic [2:0] fault_sync;
  logic       fault_level;
  logic       fault_now;
  logic       unlocked;
  logic       wr_ctl;
  logic       wr_en_reg;

  assign unlocked  = (write_lock == `PWF_UNLOCK_KEY);
  assign wr_ctl    = reg_wr && unlocked && (reg_addr == `PWF_OFS_CONTROL);
  assign wr_en_reg = reg_wr && unlocked && (reg_addr == `PWF_OFS_MODULE_ENABLE);
  assign running   = primary_output_enable || complement_output_enable;

  // Lock register is always writable; it guards enable, control, period and duty
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      write_lock <= `PWF_RST_BYTE;
    end else if (reg_wr && reg_addr == `PWF_OFS_WRITE_LOCK) begin
      write_lock <= reg_wdata;
    end
  end

  // Module enable register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fault_detect_enable      <= 1'b0;
      complement_output_enable <= 1'b0;
      primary_output_enable    <= 1'b0;
    end else if (wr_en_reg) begin
      fault_detect_enable      <= reg_wdata[`PWF_EN_FAULT_DETECT];
      complement_output_enable <= reg_wdata[`PWF_EN_COMPLEMENT];
      primary_output_enable    <= reg_wdata[`PWF_EN_PRIMARY];
    end
  end

  // Control register plain fields
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      period_irq_enable  <= 1'b0;
      fault_level_select <= 1'b0;
      output_polarity    <= 1'b0;
      prescaler_select   <= PWF_PSC_DIV2;
    end else if (wr_ctl) begin
      period_irq_enable  <= reg_wdata[`PWF_CTL_IRQ_ENABLE];
      fault_level_select <= reg_wdata[`PWF_CTL_FAULT_LEVEL];
      output_polarity    <= reg_wdata[`PWF_CTL_POLARITY];
      prescaler_select   <= pwf_psc_t'(reg_wdata[`PWF_CTL_PSC_HI:`PWF_CTL_PSC_LO]);
    end
  end

  // Period and duty holding registers; settings move to the counter at a wrap
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      period_low_byte    <= `PWF_RST_BYTE;
      period_high_nibble <= 4'h0;
      duty_low_byte      <= `PWF_RST_BYTE;
      duty_high_nibble   <= 4'h0;
    end else if (reg_wr && unlocked) begin
      case (reg_addr)
        `PWF_OFS_PERIOD_LOW:  period_low_byte    <= reg_wdata;
        `PWF_OFS_PERIOD_HIGH: period_high_nibble <= reg_wdata[3:0];
        `PWF_OFS_DUTY_LOW:    duty_low_byte      <= reg_wdata;
        `PWF_OFS_DUTY_HIGH:   duty_high_nibble   <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  // System-level enable for this interrupt source
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      system_modulator_irq_enable <= 1'b0;
    end else if (reg_wr && reg_addr == `PWF_OFS_SYS_IRQ_ENABLE) begin
      system_modulator_irq_enable <= reg_wdata[`PWF_SYS_IRQ_BIT];
    end
  end

  // The divider follows the active setting so a new ratio starts with a new period
  logic [3:0] act_limit;
  always_comb begin
    case (act.prescale)
      PWF_PSC_DIV2:  act_limit = `PWF_DIV2_M1;
      PWF_PSC_DIV4:  act_limit = `PWF_DIV4_M1;
      PWF_PSC_DIV8:  act_limit = `PWF_DIV8_M1;
      PWF_PSC_DIV16: act_limit = `PWF_DIV16_M1;
      default:       act_limit = `PWF_DIV2_M1;
    endcase
  end

  assign tick = running && (psc_cnt >= act_limit);

  always_ff @(posedge clk_sys) begin
    if (!nrst || !running) begin
      psc_cnt <= 4'h0;
    end else if (tick) begin
      psc_cnt <= 4'h0;
    end else begin
      psc_cnt <= psc_cnt + 4'h1;
    end
  end

  // Period counter: 0 .. period-1, a zero period wraps on every tick
  assign wrap = tick && ((act.period == 12'h000) || (cnt >= act.period - 12'h001));

  always_ff @(posedge clk_sys) begin
    if (!nrst || !running) begin
      cnt <= 12'h000;
    end else if (wrap) begin
      cnt <= 12'h000;
    end else if (tick) begin
      cnt <= cnt + 12'h001;
    end
  end

  // While stopped the settings track software directly; while running only at a wrap
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      act <= '0;
    end else if (!running || wrap) begin
      act.polarity <= output_polarity;
      act.prescale <= prescaler_select;
      act.period   <= {period_high_nibble, period_low_byte};
      act.duty     <= {duty_high_nibble, duty_low_byte};
    end
  end

  // Overflow flag: the hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      period_irq_flag <= 1'b0;
    end else if (wrap) begin
      period_irq_flag <= 1'b1;
    end else if (wr_ctl && !reg_wdata[`PWF_CTL_IRQ_FLAG]) begin
      period_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= period_irq_flag && period_irq_enable && system_modulator_irq_enable;
    end
  end

  // Fault pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fault_sync <= 3'b000;
    end else begin
      fault_sync <= {fault_sync[1:0], fault_pin};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fault_level <= 1'b1;
    end else if (fault_sync[1] == fault_sync[2]) begin
      fault_level <= fault_sync[1];
    end
  end

  // Reset value of the filtered level is high, so level-low select sees no fault at start
  assign fault_now = fault_detect_enable &&
                     (fault_level == fault_level_select);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      fault_status <= 1'b0;
    end else if (fault_now) begin
      fault_status <= 1'b1;
    end else if (wr_ctl && !reg_wdata[`PWF_CTL_FAULT_STATUS]) begin
      fault_status <= 1'b0;
    end
  end

  // Waveform, before polarity
  always_comb begin
    if (act.period == 12'h000) begin
      raw_level = 1'b0;
    end else if (act.period <= act.duty) begin
      raw_level = 1'b1;
    end else begin
      raw_level = (cnt < act.duty);
    end
  end

  // Inactive level equals the polarity bit on both outputs
  always_comb begin
    next_primary    = act.polarity;
    next_complement = act.polarity;
    if (!fault_status) begin
      if (primary_output_enable) begin
        next_primary = raw_level ^ act.polarity;
      end
      if (complement_output_enable) begin
        next_complement = ~raw_level ^ act.polarity;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      primary_output       <= 1'b0;
      complementary_output <= 1'b0;
      primary_pin_en       <= 1'b0;
      complement_pin_en    <= 1'b0;
    end else begin
      primary_output       <= next_primary;
      complementary_output <= next_complement;
      primary_pin_en       <= primary_output_enable;
      complement_pin_en    <= complement_output_enable;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= `PWF_RST_BYTE;
    end else if (reg_rd) begin
      case (reg_addr)
        `PWF_OFS_MODULE_ENABLE:
          reg_rdata <= {1'b0, fault_detect_enable, 2'b00, complement_output_enable,
                        2'b00, primary_output_enable};
        `PWF_OFS_CONTROL:
          reg_rdata <= {period_irq_enable, period_irq_flag, 1'b0, fault_status,
                        fault_level_select, output_polarity, prescaler_select};
        `PWF_OFS_PERIOD_LOW:     reg_rdata <= period_low_byte;
        `PWF_OFS_PERIOD_HIGH:    reg_rdata <= {4'h0, period_high_nibble};
        `PWF_OFS_DUTY_LOW:       reg_rdata <= duty_low_byte;
        `PWF_OFS_DUTY_HIGH:      reg_rdata <= {4'h0, duty_high_nibble};
        `PWF_OFS_WRITE_LOCK:     reg_rdata <= write_lock;
        `PWF_OFS_SYS_IRQ_ENABLE: reg_rdata <= {7'h00, system_modulator_irq_enable};
        default:                 reg_rdata <= `PWF_RST_BYTE;
      endcase
    end else begin
      reg_rdata <= `PWF_RST_BYTE;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_lock_blocks_write: assert property (
    (reg_wr && !unlocked)
      |=> $stable({period_low_byte, period_high_nibble, duty_low_byte, duty_high_nibble,
                   fault_detect_enable, complement_output_enable, primary_output_enable}))
    else $error("guarded write passed a closed lock");

  a_wrap_sets_flag: assert property (wrap |=> period_irq_flag)
    else $error("overflow did not set flag");

  a_flag_sticky: assert property (
    (period_irq_flag && !(wr_ctl && !reg_wdata[`PWF_CTL_IRQ_FLAG])) |=> period_irq_flag)
    else $error("flag dropped without a clear");

  a_irq_gating: assert property (
    irq_req |-> ($past(period_irq_enable) && $past(system_modulator_irq_enable)))
    else $error("interrupt raised while masked");

  a_fault_sets: assert property (fault_now |=> fault_status)
    else $error("fault did not set status");

  a_fault_holds: assert property (
    (fault_now && wr_ctl && !reg_wdata[`PWF_CTL_FAULT_STATUS]) |=> fault_status)
    else $error("fault status cleared under live fault");

  a_fault_clear: assert property (
    (fault_status && !fault_now && wr_ctl && !reg_wdata[`PWF_CTL_FAULT_STATUS])
      |=> !fault_status)
    else $error("fault status clear ignored");

  a_fault_inactive: assert property (
    fault_status |=> (primary_output == $past(act.polarity)) &&
                     (complementary_output == $past(act.polarity)))
    else $error("outputs active during fault");

  a_zero_period: assert property (
    (primary_output_enable && !fault_status && act.period == 12'h000)
      |=> primary_output == $past(act.polarity))
    else $error("zero period not at rest level");

  a_full_duty: assert property (
    (primary_output_enable && !fault_status && act.period != 12'h000 &&
     act.period <= act.duty) |=> primary_output != $past(act.polarity))
    else $error("full duty not at active level");

  a_comp_inverse: assert property (
    (primary_output_enable && complement_output_enable && !fault_status)
      |=> complementary_output != primary_output)
    else $error("complementary output not inverted");

  a_div2_spacing: assert property (
    (tick && !wrap && act.prescale == PWF_PSC_DIV2) |=> !tick ##1 (tick || !running))
    else $error("divide by two spacing wrong");

  a_disable_rest: assert property (
    !primary_output_enable |=> primary_output == $past(act.polarity))
    else $error("disabled output not at rest level");

  c_wrap: cover property (wrap && act.period != 12'h000);
  c_fault_clear: cover property (fault_status ##1 !fault_status);
  c_fault: cover property (fault_now && !fault_status);
  c_irq: cover property ($rose(irq_req));

endmodule : pwf_modulator

/* test/pwf_stage_model.sv */
`timescale 1ns/1ps
module pwf_stage_model (
  input  wire logic fault_req, // Bench asks the stage to report a fault
  input  wire logic fault_lvl, // Level the stage uses to report a fault
  output logic      fault_pin  // Fault line back to the modulator
);
  // The line has no pull resistor, so the stage drives it at all times
  assign fault_pin = fault_req ? fault_lvl : ~fault_lvl;
endmodule : pwf_stage_model

/* test/test_pwf_modulator.sv */
`timescale 1ns/1ps
`include "pwf_map.svh"
module test_pwf_modulator;
  logic       clk_sys, nrst, reg_wr, reg_rd, fault_pin, fault_req, fault_lvl;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic       primary_output, complementary_output, primary_pin_en, complement_pin_en;
  logic       irq_req;
  logic       rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] map_a [8] = '{8'hCF, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hE7, 8'hE8};
  int         n_fail = 0, n_checks = 0, n_cyc = 0, seed, hi, lo;

  pwf_modulator pwf_modulator_i (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fault_pin(fault_pin), .primary_output(primary_output),
    .complementary_output(complementary_output), .primary_pin_en(primary_pin_en),
    .complement_pin_en(complement_pin_en), .irq_req(irq_req));
  pwf_stage_model pwf_stage_model_i (.fault_req(fault_req), .fault_lvl(fault_lvl),
    .fault_pin(fault_pin));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe, so compare there
  always @(posedge clk_sys) begin
    if (rd_q) chk(reg_rdata, exp_q.pop_front());
    rd_q <= reg_rd;
    n_cyc <= n_cyc + 1;
    if (n_cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask : rd

  task cfg(input logic [7:0] ctl, p, d, en);
    wr(`PWF_OFS_WRITE_LOCK, `PWF_UNLOCK_KEY);
    wr(`PWF_OFS_MODULE_ENABLE, 8'h00);
    wr(`PWF_OFS_CONTROL, ctl);
    wr(`PWF_OFS_PERIOD_LOW, p);
    wr(`PWF_OFS_PERIOD_HIGH, 8'h00);
    wr(`PWF_OFS_DUTY_LOW, d);
    wr(`PWF_OFS_DUTY_HIGH, 8'h00);
    wr(`PWF_OFS_MODULE_ENABLE, en);
    repeat (4) @(posedge clk_sys);
  endtask : cfg

  // Waits for a rising edge, then counts one high and one low stretch
  task meas(input bit c, output int n1, output int n0);
    int   t;
    logic s;
    n1 = 0;
    n0 = 0;
    t = 0;
    for (int ph = 0; ph < 4; ph++) begin
      s = c ? complementary_output : primary_output;
      while ((ph < 2 ? s !== ph[0] : s === (ph == 2)) && t < 400) begin
        if (ph == 2) n1++;
        if (ph == 3) n0++;
        @(posedge clk_sys);
        t++;
        s = c ? complementary_output : primary_output;
      end
    end
  endtask : meas

  task steady(input logic ep, input logic ec, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      chk({6'h00, primary_output, complementary_output}, {6'h00, ep, ec});
    end
  endtask : steady

  initial begin
    seed = 32'h1CD7F4B5;
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fault_req = 1'b0;
    fault_lvl = 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    foreach (map_a[i]) rd(map_a[i], `PWF_RST_BYTE);
    rd(8'h10, 8'h00);
    wr(`PWF_OFS_MODULE_ENABLE, 8'h09);
    rd(`PWF_OFS_MODULE_ENABLE, 8'h00);
    wr(`PWF_OFS_WRITE_LOCK, `PWF_UNLOCK_KEY);
    repeat (4) begin
      rv = 8'($random(seed));
      wr(`PWF_OFS_PERIOD_LOW, rv);
      wr(`PWF_OFS_PERIOD_HIGH, rv);
      wr(`PWF_OFS_DUTY_LOW, ~rv);
      wr(`PWF_OFS_DUTY_HIGH, ~rv);
      rd(`PWF_OFS_PERIOD_HIGH, {4'h0, rv[3:0]});
      rd(`PWF_OFS_DUTY_HIGH, {4'h0, ~rv[3:0]});
    end
    wr(`PWF_OFS_WRITE_LOCK, 8'h00);
    wr(`PWF_OFS_DUTY_LOW, rv);
    rd(`PWF_OFS_DUTY_LOW, ~rv);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      cfg(8'(k), 8'h04, 8'h01, 8'h09);
      meas(1'b0, hi, lo);
      chk(8'(hi), 8'(2 << k));
      chk(8'(lo), 8'(6 << k));
    end
    meas(1'b1, hi, lo);
    chk(8'(hi), 8'd48);
    chk(8'(lo), 8'd16);
    chk({6'h00, primary_pin_en, complement_pin_en}, 8'h03);
    cfg(8'h04, 8'h04, 8'h01, 8'h09);
    meas(1'b0, hi, lo);
    chk(8'(hi), 8'd6);
    cfg(8'h00, 8'h04, 8'h01, 8'h08);
    meas(1'b1, hi, lo);
    chk(8'(hi), 8'd6);
    chk({6'h00, primary_output, primary_pin_en}, 8'h00);
    $display("test waveform done");
    cfg(8'h00, 8'h04, 8'h01, 8'h09);
    meas(1'b0, hi, lo);
    wr(`PWF_OFS_DUTY_LOW, 8'h03);
    @(posedge clk_sys);
    chk({7'h00, primary_output}, 8'h00);
    meas(1'b0, hi, lo);
    chk(8'(hi), 8'd6);
    for (int pol = 0; pol < 2; pol++) begin
      cfg(8'(pol << 2), 8'h00, 8'h05, 8'h01);
      steady(pol[0], pol[0], 20);
      cfg(8'(pol << 2), 8'h03, 8'h03, 8'h01);
      steady(!pol[0], pol[0], 20);
    end
    $display("test limits done");
    for (int lv = 0; lv < 2; lv++) begin
      rv = lv ? 8'h0C : 8'h00;
      fault_lvl <= lv[0];
      cfg(rv, 8'h04, 8'h01, 8'h49);
      fault_req <= 1'b1;
      repeat (12) @(posedge clk_sys);
      steady(lv[0], lv[0], 16);
      rd(`PWF_OFS_CONTROL, 8'h50 | rv);
      wr(`PWF_OFS_CONTROL, 8'h40 | rv);
      rd(`PWF_OFS_CONTROL, 8'h50 | rv);
      fault_req <= 1'b0;
      repeat (6) @(posedge clk_sys);
      wr(`PWF_OFS_CONTROL, 8'h40 | rv);
      rd(`PWF_OFS_CONTROL, 8'h40 | rv);
      meas(1'b0, hi, lo);
      chk(8'(hi), lv ? 8'd6 : 8'd2);
    end
    fault_lvl <= 1'b0;
    cfg(8'h00, 8'h04, 8'h01, 8'h09);
    fault_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    meas(1'b0, hi, lo);
    chk(8'(hi), 8'd2);
    fault_req <= 1'b0;
    $display("test fault done");
    cfg(8'h80, 8'h04, 8'h01, 8'h09);
    wr(`PWF_OFS_SYS_IRQ_ENABLE, 8'h00);
    repeat (20) @(posedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    rd(`PWF_OFS_CONTROL, 8'hC0);
    wr(`PWF_OFS_SYS_IRQ_ENABLE, 8'h01);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irq_req}, 8'h01);
    wr(`PWF_OFS_MODULE_ENABLE, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk({5'h00, primary_output, primary_pin_en, complement_pin_en}, 8'h00);
    wr(`PWF_OFS_CONTROL, 8'h80);
    rd(`PWF_OFS_CONTROL, 8'h80);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, irq_req}, 8'h00);
    wr(`PWF_OFS_WRITE_LOCK, 8'hAA);
    $display("test interrupt done");
    repeat (4) @(posedge clk_sys);
    test_done();
  end
endmodule : test_pwf_modulator
